// ---- logic/policy_pkg.sv ----
package policy_pkg;

  localparam int NUM_PORTS = 3;

  // Register indices; the byte address of a register is four times its index.
  localparam logic [7:0] PORT_BASE_IDX = 8'h10;
  localparam logic [7:0] PORT_STRIDE_IDX = 8'h10;
  localparam logic [7:0] SLOT_QUEUE_CTRL = 8'h00;
  localparam logic [7:0] SLOT_CTRL_A = 8'h01;
  localparam logic [7:0] SLOT_CTRL_B = 8'h02;
  localparam logic [7:0] SLOT_TAG_HI = 8'h03;
  localparam logic [7:0] SLOT_TAG_LO = 8'h04;
  localparam logic [7:0] PORT1_POLICY_CTRL_B_IDX = 8'h12;
  localparam logic [7:0] PORT2_POLICY_CTRL_B_IDX = 8'h22;
  localparam logic [7:0] PORT3_POLICY_CTRL_B_IDX = 8'h32;

  // Fields of port_mirror_vlan_ctrl_a.
  localparam int MIRROR_DEST_BIT = 7;
  localparam int RX_MONITOR_BIT = 6;
  localparam int TX_MONITOR_BIT = 5;
  localparam int DOUBLE_TAG_BIT = 4;
  localparam int PRIO_CEIL_BIT = 3;
  localparam int MEMBER_MSB = 2;
  localparam int MEMBER_LSB = 0;

  // Fields of portN_policy_ctrl_b.
  localparam int SPLIT2_BIT = 7;
  localparam int INGRESS_FILTER_BIT = 6;
  localparam int DISCARD_NON_DEFAULT_BIT = 5;
  localparam logic [7:0] CTRL_B_WMASK = 8'hE0;

  // Queue control holds only the four-queue split bit.
  localparam int SPLIT4_BIT = 0;

  // Default tag layout: priority in the top three bits, VID in the low twelve.
  localparam int TAG_PRIO_MSB = 15;
  localparam int TAG_PRIO_LSB = 13;
  localparam int TAG_VID_MSB = 11;

  localparam logic [7:0] CTRL_A_RESET = 8'h07;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] TAG_HI_RESET = 8'h00;
  localparam logic [7:0] TAG_LO_RESET = 8'h01;
  localparam logic SPLIT4_RESET = 1'b0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- logic/port_policy_decide.sv ----
`timescale 1ns/1ps

// Combinational forwarding policy for one frame, from the current register image.
module port_policy_decide (
  input wire logic [policy_pkg::NUM_PORTS-1:0][7:0] ctrl_a,
  input wire logic [policy_pkg::NUM_PORTS-1:0][7:0] ctrl_b,
  input wire logic [policy_pkg::NUM_PORTS-1:0][15:0] def_tag,
  input wire logic [1:0] ingress_port,
  input wire logic [11:0] vid,
  input wire logic [2:0] prio,
  input wire logic [policy_pkg::NUM_PORTS-1:0] fwd_map,
  input wire logic [policy_pkg::NUM_PORTS-1:0] vlan_member,
  output logic drop,
  output logic [policy_pkg::NUM_PORTS-1:0] dest_map,
  output logic monitored,
  output logic double_tag,
  output logic [15:0] out_tag,
  output logic [2:0] out_prio
);
  import policy_pkg::*;

  logic [NUM_PORTS-1:0] mirror_ports;
  logic [NUM_PORTS-1:0] tx_watch;
  logic [7:0] a;
  logic [7:0] b;
  logic [15:0] pt;
  logic [NUM_PORTS-1:0] member;
  logic bad_port;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign mirror_ports[p] = ctrl_a[p][MIRROR_DEST_BIT];
    assign tx_watch[p] = ctrl_a[p][TX_MONITOR_BIT];
  end

  // An ingress index beyond the last port selects nothing and drops the frame.
  assign bad_port = (ingress_port > 2'(NUM_PORTS - 1));
  assign a = bad_port ? 8'h00 : ctrl_a[ingress_port];
  assign b = bad_port ? 8'h00 : ctrl_b[ingress_port];
  assign pt = bad_port ? 16'h0000 : def_tag[ingress_port];
  // Bit 0 is port 1, bit 1 port 2, bit 2 port 3, same order as fwd_map.
  assign member = a[MEMBER_MSB:MEMBER_LSB];

  always_comb begin
    drop = bad_port;
    if (b[INGRESS_FILTER_BIT] && !bad_port && !vlan_member[ingress_port]) begin
      drop = 1'b1;
    end
    if (b[DISCARD_NON_DEFAULT_BIT] && (vid != pt[TAG_VID_MSB:0])) begin
      drop = 1'b1;
    end
    dest_map = fwd_map & member;
    monitored = a[RX_MONITOR_BIT] || (|(dest_map & tx_watch));
    if (drop) begin
      monitored = 1'b0;
      dest_map = '0;
    end else if (monitored) begin
      dest_map = dest_map | mirror_ports;
    end
    double_tag = a[DOUBLE_TAG_BIT] && !drop;
    out_tag = pt;
    out_prio = prio;
    if (a[PRIO_CEIL_BIT] && (prio > pt[TAG_PRIO_MSB:TAG_PRIO_LSB])) begin
      out_prio = pt[TAG_PRIO_MSB:TAG_PRIO_LSB];
    end
  end

endmodule

// ---- logic/port_mirror_vlan_policy_ctrl.sv ----
`timescale 1ns/1ps

module port_mirror_vlan_policy_ctrl #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic req_valid,
  input wire logic [1:0] req_ingress_port,
  input wire logic [11:0] req_vid,
  input wire logic [2:0] req_prio,
  input wire logic [policy_pkg::NUM_PORTS-1:0] req_fwd_map,
  input wire logic [policy_pkg::NUM_PORTS-1:0] req_vlan_member,
  output logic res_valid,
  output logic res_drop,
  output logic [policy_pkg::NUM_PORTS-1:0] res_dest_map,
  output logic res_monitored,
  output logic res_double_tag,
  output logic [15:0] res_tag,
  output logic [2:0] res_prio,
  output logic [policy_pkg::NUM_PORTS-1:0] txq_split4,
  output logic [policy_pkg::NUM_PORTS-1:0] txq_split2
);
  import policy_pkg::*;

  // The whole block state lives in one record, so reset and next-state logic stay in one place.
  typedef struct packed {
    logic awready;
    logic aw_have;
    logic [ADDR_W-1:0] awaddr;
    logic wready;
    logic w_have;
    logic [7:0] wbyte;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [NUM_PORTS-1:0] split4;
    logic [NUM_PORTS-1:0] split2;
    logic [NUM_PORTS-1:0][7:0] ctrl_a;
    logic [NUM_PORTS-1:0][7:0] ctrl_b;
    logic [NUM_PORTS-1:0][15:0] def_tag;
    logic res_valid;
    logic res_drop;
    logic [NUM_PORTS-1:0] res_dest;
    logic res_mon;
    logic res_dtag;
    logic [15:0] res_tag;
    logic [2:0] res_prio;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic dec_drop;
  logic [NUM_PORTS-1:0] dec_dest;
  logic dec_mon;
  logic dec_dtag;
  logic [15:0] dec_tag;
  logic [2:0] dec_prio;

  // Finds which port block and which slot a word address selects.
  // The two low address bits are ignored, so an unaligned access lands on its enclosing word.
  function automatic logic find_reg(input logic [ADDR_W-1:0] addr, output logic [1:0] port,
                                    output logic [7:0] slot);
    logic [7:0] idx;
    logic hit;
    idx = {2'h0, addr[7:2]};
    hit = 1'b0;
    port = 2'h0;
    slot = 8'h00;
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int k = 0; k <= int'(SLOT_TAG_LO); k++) begin
        if (idx == PORT_BASE_IDX + 8'(p) * PORT_STRIDE_IDX + 8'(k)) begin
          hit = 1'b1;
          port = 2'(p);
          slot = 8'(k);
        end
      end
    end
    return hit;
  endfunction

  // Reset image of the whole state.
  function automatic state_t reset_state();
    state_t r;
    r = '0;
    // Ready signals start high so the first access after reset is taken at once.
    r.awready = 1'b1;
    r.wready = 1'b1;
    r.arready = 1'b1;
    for (int p = 0; p < NUM_PORTS; p++) begin
      r.ctrl_a[p] = CTRL_A_RESET;
      r.ctrl_b[p] = CTRL_B_RESET;
      r.def_tag[p] = {TAG_HI_RESET, TAG_LO_RESET};
      r.split4[p] = SPLIT4_RESET;
    end
    return r;
  endfunction

  // The policy decision is purely combinational from the register image; only its result is
  // registered, which keeps the answer exactly one cycle after the request.
  port_policy_decide u_decide (
    .ctrl_a(s_q.ctrl_a),
    .ctrl_b(s_q.ctrl_b),
    .def_tag(s_q.def_tag),
    .ingress_port(req_ingress_port),
    .vid(req_vid),
    .prio(req_prio),
    .fwd_map(req_fwd_map),
    .vlan_member(req_vlan_member),
    .drop(dec_drop),
    .dest_map(dec_dest),
    .monitored(dec_mon),
    .double_tag(dec_dtag),
    .out_tag(dec_tag),
    .out_prio(dec_prio)
  );

  always_comb begin
    logic [1:0] wport;
    logic [7:0] wslot;
    logic whit;
    logic [1:0] rport;
    logic [7:0] rslot;
    logic rhit;
    wport = 2'h0;
    wslot = 8'h00;
    rport = 2'h0;
    rslot = 8'h00;
    whit = 1'b0;
    rhit = 1'b0;
    s_d = s_q;

    // Write path: address and data may arrive in either order.
    // Whichever half comes first waits in the state until the other one arrives.
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wbyte = s_axi_wdata[7:0];
      s_d.wlane0 = s_axi_wstrb[0];
    end
    whit = find_reg(s_d.awaddr, wport, wslot);
    if (s_d.aw_have && s_d.w_have && !s_d.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      // An address outside the port blocks is answered with an error and changes nothing.
      s_d.bresp = whit ? RESP_OKAY : RESP_SLVERR;
      // Registers are one byte wide, so only lane 0 carries data.
      if (whit && s_d.wlane0) begin
        case (wslot)
          SLOT_QUEUE_CTRL: begin
            s_d.split4[wport] = s_d.wbyte[SPLIT4_BIT];
          end
          SLOT_CTRL_A: begin
            s_d.ctrl_a[wport] = s_d.wbyte;
          end
          SLOT_CTRL_B: begin
            // Bits 4 to 0 are not implemented here and always read back as zero.
            s_d.ctrl_b[wport] = s_d.wbyte & CTRL_B_WMASK;
          end
          SLOT_TAG_HI: begin
            s_d.def_tag[wport][15:8] = s_d.wbyte;
          end
          SLOT_TAG_LO: begin
            s_d.def_tag[wport][7:0] = s_d.wbyte;
          end
          default: begin
            s_d.bresp = RESP_SLVERR;
          end
        endcase
      end
    end
    // New writes are refused while a response waits, so at most one write is in flight.
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready = !s_d.w_have && !s_d.bvalid;

    // Queue split outputs follow the registers in the same edge.
    for (int p = 0; p < NUM_PORTS; p++) begin
      // If software breaks the exclusion, the four-queue split wins.
      s_d.split2[p] = s_d.ctrl_b[p][SPLIT2_BIT] && !s_d.split4[p];
    end

    // Read path: one outstanding read, answered one edge after it is taken.
    // Data come from the registers as they stood before the edge, so a read that meets a write to
    // the same register in one cycle returns the old value.
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    rhit = find_reg(s_axi_araddr, rport, rslot);
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = rhit ? RESP_OKAY : RESP_SLVERR;
      s_d.rdata = 32'h0000_0000;
      if (rhit) begin
        case (rslot)
          SLOT_QUEUE_CTRL: begin
            s_d.rdata[SPLIT4_BIT] = s_q.split4[rport];
          end
          SLOT_CTRL_A: begin
            s_d.rdata[7:0] = s_q.ctrl_a[rport];
          end
          SLOT_CTRL_B: begin
            s_d.rdata[7:0] = s_q.ctrl_b[rport];
          end
          SLOT_TAG_HI: begin
            s_d.rdata[7:0] = s_q.def_tag[rport][15:8];
          end
          SLOT_TAG_LO: begin
            s_d.rdata[7:0] = s_q.def_tag[rport][7:0];
          end
          default: begin
            s_d.rresp = RESP_SLVERR;
          end
        endcase
      end
    end
    // The next read address is refused until the present data have been taken.
    s_d.arready = !s_d.rvalid;

    // Decisions use the register image as it stood before this edge's write.
    // A request never waits; the result fields hold until the next request replaces them.
    s_d.res_valid = req_valid;
    if (req_valid) begin
      s_d.res_drop = dec_drop;
      s_d.res_dest = dec_dest;
      s_d.res_mon = dec_mon;
      s_d.res_dtag = dec_dtag;
      s_d.res_tag = dec_tag;
      s_d.res_prio = dec_prio;
    end
  end

  // The reset is synchronous and puts the whole record back to its reset image in one edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= reset_state();
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a plain copy of a register, so no combinational path reaches a port.
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign res_valid = s_q.res_valid;
  assign res_drop = s_q.res_drop;
  assign res_dest_map = s_q.res_dest;
  assign res_monitored = s_q.res_mon;
  assign res_double_tag = s_q.res_dtag;
  assign res_tag = s_q.res_tag;
  assign res_prio = s_q.res_prio;
  assign txq_split4 = s_q.split4;
  assign txq_split2 = s_q.split2;

endmodule

// ---- dv/policy_props.sv ----
`timescale 1ns/1ps

module policy_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic req_valid,
  input wire logic [1:0] req_ingress_port,
  input wire logic res_valid,
  input wire logic res_drop,
  input wire logic [policy_pkg::NUM_PORTS-1:0] res_dest_map,
  input wire logic [policy_pkg::NUM_PORTS-1:0] txq_split4,
  input wire logic [policy_pkg::NUM_PORTS-1:0] txq_split2
);
  import policy_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_res_latency: assert property (req_valid |=> res_valid)
    else $error("result missing");
  a_res_pulse: assert property (!req_valid |=> !res_valid)
    else $error("stray result");
  a_res_hold: assert property (!req_valid |=> $stable(res_drop) && $stable(res_dest_map))
    else $error("result moved");
  a_bad_port: assert property (req_valid && req_ingress_port == 2'h3 |=> res_drop)
    else $error("bad port kept");
  a_drop_empty: assert property (res_valid && res_drop |-> res_dest_map == 3'h0)
    else $error("dropped frame forwarded");
  a_split_excl: assert property ((txq_split4 & txq_split2) == 3'h0)
    else $error("both splits on");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp moved");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  cover property (res_valid && res_drop);
  cover property (res_valid && res_dest_map == 3'h6);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind port_mirror_vlan_policy_ctrl policy_props u_props (.*);

// ---- dv/tb.sv ----
`timescale 1ns/1ps

module tb;
  import policy_pkg::*;
  typedef struct packed {
    logic [7:0] a, d;
    logic [1:0] p;
    logic [11:0] v;
    logic [2:0] pr, f, m;
    logic dr;
    logic [2:0] dm;
    logic mo, dt;
    logic [2:0] po;
  } row_t;
  logic aclk = 0, aresetn = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, req_valid = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] req_ingress_port = 0, s_axi_bresp, s_axi_rresp;
  logic [11:0] req_vid = 0;
  logic [2:0] req_prio = 0, req_fwd_map = 0, req_vlan_member = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic res_valid, res_drop, res_monitored, res_double_tag;
  logic [2:0] res_dest_map, res_prio, txq_split4, txq_split2;
  logic [15:0] res_tag;
  logic [7:0] rst_v [5] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h01};
  int err_total = 0, checks_done = 0;
  // The write ahead of each frame shows that new settings reach the very next decision.
  row_t rows [13] = '{
    '{'h44,'h07,0,1,5,6,7,0,6,0,0,5}, '{'h44,'h05,0,1,5,7,7,0,5,0,0,5},
    '{'h44,'h0F,0,1,5,7,7,0,7,0,0,0}, '{'h4C,'hA0,0,1,7,7,7,0,7,0,0,5},
    '{'h44,'h17,0,1,7,7,7,0,7,0,1,7}, '{'h44,'h47,0,1,3,2,7,0,2,1,0,3},
    '{'h84,'h87,0,1,3,4,7,0,6,1,0,3}, '{'h44,'h07,0,1,3,4,7,0,4,0,0,3},
    '{'hC4,'h27,0,1,3,4,7,0,6,1,0,3}, '{'h48,'h40,0,1,3,1,6,1,0,0,0,0},
    '{'h48,'h40,0,1,3,1,3,0,1,0,0,3}, '{'h48,'h20,0,2,3,1,7,1,0,0,0,0},
    '{'h48,'h20,0,1,3,1,1,0,1,0,0,3}};

  port_mirror_vlan_policy_ctrl DUT (.*);

  always #4 aclk = ~aclk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, d, input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  task automatic dec(input logic [1:0] p, input logic [11:0] v, input logic [2:0] pr, f, m);
    @(posedge aclk);
    req_valid <= 1;
    req_ingress_port <= p;
    req_vid <= v;
    req_prio <= pr;
    req_fwd_map <= f;
    req_vlan_member <= m;
    @(posedge aclk);
    req_valid <= 0;
    #1;
    chk(res_valid, 1);
  endtask

  task automatic rst_chk();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 5; i++) begin
      rd(8'h40 + 8'(i * 4), d, r);
      chk(d, rst_v[i]);
    end
    chk(txq_split4, 0);
    chk(txq_split2, 0);
  endtask

  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #20000;
    err_total++;
    end_of_test();
  end

  initial begin
    row_t w;
    logic [31:0] d;
    logic [1:0] r;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rst_chk();
    foreach (rows[i]) begin
      w = rows[i];
      wr(w.a, w.d, 4'hF, r);
      chk(r, RESP_OKAY);
      dec(w.p, w.v, w.pr, w.f, w.m);
      chk(res_drop, w.dr);
      chk(res_dest_map, w.dm);
      if (!w.dr) begin
        chk(res_monitored, w.mo);
        chk(res_double_tag, w.dt);
        chk(res_prio, w.pr > 3'h5 && w.po == 3'h5 ? 3'h5 : w.po);
      end
    end
    dec(2'h0, 12'h001, 3'h0, 3'h1, 3'h7);
    chk(res_tag, 16'hA001);
    dec(2'h3, 12'h001, 3'h0, 3'h7, 3'h7);
    chk(res_drop, 1);
    wr(8'h88, 8'hFF, 4'hF, r);
    wr(8'h40, 8'h01, 4'hF, r);
    wr(8'h88, 8'h00, 4'h0, r);
    rd(8'h88, d, r);
    chk(d, 32'hE0);
    chk(txq_split2, 3'h2);
    chk(txq_split4, 3'h1);
    wr(8'h54, 8'hFF, 4'hF, r);
    chk(r, RESP_SLVERR);
    rd(8'h54, d, r);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    // A response left waiting must hold still until it is taken; this write moves the default VID.
    @(posedge aclk);
    s_axi_awaddr <= 8'h50;
    s_axi_wdata <= 32'h0000_0002;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge aclk);
    end while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    repeat (2) @(posedge aclk);
    chk(s_axi_bvalid, 1);
    s_axi_bready <= 1;
    @(posedge aclk);
    s_axi_bready <= 0;
    chk(s_axi_bresp, RESP_OKAY);
    dec(2'h0, 12'h002, 3'h0, 3'h1, 3'h7);
    chk(res_drop, 0);
    chk(res_tag, 16'hA002);
    @(posedge aclk);
    aresetn <= 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rst_chk();
    end_of_test();
  end
endmodule
